// ---- logic/admtc_pkg.sv ----
// Purpose: Shared constants for the converter mode and trigger control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Register offsets are byte addresses
package admtc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_MODE0 = 8'h00;
  localparam logic [7:0] OFF_TRIG = 8'h04;
  localparam logic [7:0] OFF_REFLIM = 8'h08;
  localparam logic [7:0] OFF_PINDIR = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFF_START = 8'h1c;
  // Mode register 0 fields
  localparam int B_RUN = 7;
  localparam int B_CHSEL = 6;
  localparam int B_DIV_LO = 3;
  localparam int B_TMODE_LO = 1;
  localparam int B_CMP = 0;
  // Trigger register fields
  localparam int B_TRIGM_LO = 6;
  localparam int B_ONESHOT = 5;
  localparam int B_TSRC_LO = 0;
  localparam logic [7:0] TRIG_WMASK = 8'he3;
  // Reference register fields
  localparam int B_REFP_LO = 6;
  localparam logic [7:0] REFLIM_WMASK = 8'hed;
  // Reset values
  localparam logic [7:0] RST_MODE0 = 8'h00;
  localparam logic [7:0] RST_TRIG = 8'h00;
  localparam logic [7:0] RST_REFLIM = 8'h00;
  localparam logic RST_PINDIR = 1'b1;
  // Status bit positions
  localparam int S_DONE = 0;
  localparam int S_BADCFG = 1;
  localparam int NUM_EVT = 2;
  // Timing
  localparam int CLK_MHZ = 20;
  localparam int CONV_CLOCKS = 19;
  localparam int STAB_NS = 1000;
  localparam int STAB_CYC = (STAB_NS * CLK_MHZ + 999) / 1000;
  // Trigger modes and prohibited reference code
  localparam logic [1:0] TM_HW_NOWAIT = 2'b10;
  localparam logic [1:0] TM_HW_WAIT = 2'b11;
  localparam logic [1:0] REFP_BAD = 2'b11;
endpackage : admtc_pkg

// ---- logic/admtc_div_if.sv ----
// Purpose: Carries divider selection and its tick between modules
// Assumes: Single clock
// Notes: None
`timescale 1ns/100ps
interface admtc_div_if;
  logic [2:0] code; // Divider code
  logic run; // Divider running
  logic tick; // One-cycle enable
  modport ctl (output code, output run, input tick);
  modport div (input code, input run, output tick);
endinterface : admtc_div_if

// ---- logic/admtc_clkdiv.sv ----
// Purpose: Converter clock enable divider
// Assumes: Code 0..7 selects /64,/32,/16,/8,/6,/5,/4,/2
// Notes: Produces enable pulses, not a clock
`timescale 1ns/100ps
module admtc_clkdiv import admtc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Divider link
  admtc_div_if.div dv
);
  logic [6:0] cnt_q, cnt_d; // Cycle counter
  logic [6:0] ratio; // Selected ratio

  // Ratio table
  always_comb begin
    case (dv.code)
      3'h0: ratio = 7'h40;
      3'h1: ratio = 7'h20;
      3'h2: ratio = 7'h10;
      3'h3: ratio = 7'h08;
      3'h4: ratio = 7'h06;
      3'h5: ratio = 7'h05;
      3'h6: ratio = 7'h04;
      default: ratio = 7'h02;
    endcase
  end

  // Count up, tick on wrap
  always_comb begin
    dv.tick = 1'b0;
    cnt_d = cnt_q;
    if (!dv.run) begin
      cnt_d = 7'h00;
    end else if (cnt_q >= ratio - 7'h01) begin
      cnt_d = 7'h00;
      dv.tick = 1'b1;
    end else begin
      cnt_d = cnt_q + 7'h01;
    end
  end

  // Register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 7'h00;
    else cnt_q <= cnt_d;
  end
endmodule : admtc_clkdiv

// ---- logic/admtc_top.sv ----
// Purpose: Converter mode, trigger and reference control with APB registers
// Assumes: Hardware triggers are one-cycle pulses synchronous to pclk
// Notes: Analog core is outside; conversion length is modelled in ticks
// Operation
// [R1] Pin direction 1 input, 0 driven output
// [R2] Bit 6: select mode or scan mode
// [R3] Divider code picks /64 down to /2
// [R4] Conversion-time mode: normal 1, 2, low-voltage
// [R5] Trigger mode: software, hardware no-wait, wait
// [R6] Bit 5: sequential or one-shot
// [R7] Source: timer, event link, RTC, interval
// [R8] Software writes zero to trigger bits 4:2
// [R9] Reference register field layout
// [R10] Run bit stops or enables conversion
// [R11] Reference select code 11 prohibited
// [R12] Reference change sequence kept by software
// [R13] Prohibited clock settings flagged
// [R14] Conversion end raises interrupt flag
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module admtc_top import admtc_pkg::*; #(
  parameter int CONV_TICKS = CONV_CLOCKS,
  parameter int FCLK_MHZ = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Hardware trigger sources
  input wire logic timer_ch1_interrupt,
  input wire logic event_link_controller,
  input wire logic rtc_interrupt,
  input wire logic interval_timer_interrupt,
  // Shared pin
  input wire logic shared_port_pin_in,
  input wire logic shared_port_pin_dout,
  output logic shared_port_pin_out,
  output logic shared_port_pin_oe,
  output logic analog_input_0,
  // Converter status
  output logic conv_active,
  output logic conv_end_pulse,
  output logic [1:0] pos_reference,
  output logic irq
);
  // Elaboration check: the tick counter is eight bits wide
  if (CONV_TICKS < 1 || CONV_TICKS > 255) begin : g_bad_ticks
    $error("CONV_TICKS out of range");
  end

  typedef enum {ST_IDLE, ST_WAIT, ST_STAB, ST_CONV} admtc_state_t;

  logic [7:0] mode0_q, mode0_d; // Mode register 0
  logic [7:0] trig_q, trig_d; // Trigger mode register
  logic [7:0] reflim_q, reflim_d; // Reference and limit register
  logic pindir_q, pindir_d; // Pin direction
  logic [NUM_EVT-1:0] stat_q, stat_d; // Sticky events
  logic [NUM_EVT-1:0] ien_q, ien_d; // Interrupt enables
  admtc_state_t st_q, st_d; // Sequencer state
  logic [7:0] cnt_q, cnt_d; // Tick or cycle count
  logic [31:0] rdata_q, rdata_d; // Read data
  logic wr, rd, sw_start, hw_trig, bad_cfg, done; // Decoded strobes
  logic [1:0] tmode, trigm, tsrc, refp; // Field views
  logic [2:0] divc; // Divider code
  logic [NUM_EVT-1:0] evt; // Event vector

  admtc_div_if dvi();
  admtc_clkdiv u_div (.pclk(pclk), .presetn(presetn), .dv(dvi));

  // Field extraction
  assign divc = mode0_q[B_DIV_LO +: 3];
  assign tmode = mode0_q[B_TMODE_LO +: 2];
  assign trigm = trig_q[B_TRIGM_LO +: 2];
  assign tsrc = trig_q[B_TSRC_LO +: 2];
  assign refp = reflim_q[B_REFP_LO +: 2];
  assign dvi.code = divc; // [R3]
  assign dvi.run = (st_q == ST_CONV);

  // APB strobes; zero wait states
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = rdata_q;
  assign sw_start = wr && paddr == OFF_START && pwdata[0];

  // Hardware trigger source mux
  always_comb begin
    case (tsrc) // [R7]
      2'b00: hw_trig = timer_ch1_interrupt;
      2'b01: hw_trig = event_link_controller;
      2'b10: hw_trig = rtc_interrupt;
      default: hw_trig = interval_timer_interrupt;
    endcase
  end

  // Prohibited setting check: low-voltage modes, prohibited reference, bad ratio
  always_comb begin
    bad_cfg = tmode[1]; // [R4] [R13]
    if (refp == REFP_BAD) bad_cfg = 1'b1; // [R11]
    if (FCLK_MHZ > 16 && divc == 3'h7) bad_cfg = 1'b1; // [R13]
    if (FCLK_MHZ < 32 && divc == 3'h0) bad_cfg = 1'b1; // [R13]
    if (FCLK_MHZ < 16 && divc == 3'h1) bad_cfg = 1'b1; // [R13]
  end

  // Shared pin: driven output when direction bit is 0
  assign shared_port_pin_oe = !pindir_q; // [R1]
  assign shared_port_pin_out = shared_port_pin_dout;
  assign analog_input_0 = pindir_q & shared_port_pin_in; // [R1]
  assign pos_reference = refp; // [R9]

  // Register writes and read mux
  always_comb begin
    mode0_d = mode0_q;
    trig_d = trig_q;
    reflim_d = reflim_q;
    pindir_d = pindir_q;
    ien_d = ien_q;
    rdata_d = rdata_q;
    if (wr) begin
      case (paddr)
        OFF_MODE0: mode0_d = pwdata[7:0]; // [R2] [R10]
        OFF_TRIG: trig_d = pwdata[7:0] & TRIG_WMASK; // [R5] [R6] [R8]
        OFF_REFLIM: reflim_d = pwdata[7:0] & REFLIM_WMASK; // [R9]
        OFF_PINDIR: pindir_d = pwdata[0];
        OFF_IRQ_EN: ien_d = pwdata[NUM_EVT-1:0];
        default: ; // Status, clear, start or unmapped: no register written here
      endcase
    end
    if (rd) begin
      case (paddr)
        OFF_MODE0: rdata_d = {24'h0, conv_active, mode0_q[6:0]}; // [R10]
        OFF_TRIG: rdata_d = {24'h0, trig_q};
        OFF_REFLIM: rdata_d = {24'h0, reflim_q};
        OFF_PINDIR: rdata_d = {31'h0, pindir_q};
        OFF_STATUS: rdata_d = {30'h0, stat_q};
        OFF_IRQ_EN: rdata_d = {30'h0, ien_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // Conversion sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    done = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (mode0_q[B_RUN] && mode0_q[B_CMP] && !bad_cfg) begin // [R10]
          if (!trigm[1]) begin
            if (sw_start) st_d = ST_CONV; // [R5]
          end else begin
            st_d = ST_WAIT; // [R5]
          end
          cnt_d = 8'h00;
        end
      end
      ST_WAIT: begin
        if (hw_trig) begin
          st_d = (trigm == TM_HW_WAIT) ? ST_STAB : ST_CONV; // [R5]
          cnt_d = 8'h00;
        end
      end
      ST_STAB: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == 8'(STAB_CYC - 1)) begin
          st_d = ST_CONV;
          cnt_d = 8'h00;
        end
      end
      ST_CONV: begin
        if (dvi.tick) begin
          cnt_d = cnt_q + 8'h01;
          if (cnt_q == 8'(CONV_TICKS - 1)) begin
            done = 1'b1; // [R14]
            cnt_d = 8'h00;
            // Operation mode lives only in the trigger register
            if (trig_q[B_ONESHOT]) begin
              st_d = trigm[1] ? ST_WAIT : ST_IDLE; // [R6]
            end else begin
              st_d = ST_CONV; // [R6]
            end
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (!mode0_q[B_RUN] || !mode0_q[B_CMP] || bad_cfg) begin
      st_d = ST_IDLE; // [R10] [R13]
      cnt_d = 8'h00;
    end
  end

  assign conv_active = (st_q != ST_IDLE); // [R10]
  assign conv_end_pulse = done;

  // Sticky status: set wins over clear
  assign evt = {bad_cfg, done};
  always_comb begin
    stat_d = stat_q;
    if (wr && paddr == OFF_IRQ_CLR) stat_d = stat_q & ~pwdata[NUM_EVT-1:0];
    stat_d = stat_d | evt; // [R14] [R13]
  end
  assign irq = |(stat_q & ien_q);

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode0_q <= RST_MODE0;
      trig_q <= RST_TRIG;
      reflim_q <= RST_REFLIM;
      pindir_q <= RST_PINDIR;
      stat_q <= '0;
      ien_q <= '0;
      st_q <= ST_IDLE;
      cnt_q <= 8'h00;
      rdata_q <= 32'h0;
    end else begin
      mode0_q <= mode0_d;
      trig_q <= trig_d;
      reflim_q <= reflim_d;
      pindir_q <= pindir_d;
      stat_q <= stat_d;
      ien_q <= ien_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
    end
  end
endmodule : admtc_top

// ---- verification/admtc_top_chk.sv ----
// Purpose: Port-level checks for the converter control block
// Assumes: One clock, active-low asynchronous reset
// Notes: Bound to every admtc_top instance
`timescale 1ns/100ps
module admtc_top_chk import admtc_pkg::*; #(
  parameter int CONV_TICKS = CONV_CLOCKS,
  parameter int FCLK_MHZ = 32
) (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Pin and converter outputs
  input wire logic shared_port_pin_in,
  input wire logic shared_port_pin_dout,
  input wire logic shared_port_pin_out,
  input wire logic shared_port_pin_oe,
  input wire logic analog_input_0,
  input wire logic conv_active,
  input wire logic conv_end_pulse,
  input wire logic [1:0] pos_reference,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write accepted at the access edge
  sequence s_wr(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  chk_pin_dir: assert property (
    s_wr(OFF_PINDIR) |=> shared_port_pin_oe != $past(pwdata[0]))
    else $error("pin enable does not follow direction");
  chk_pin_drive: assert property (
    shared_port_pin_oe |-> shared_port_pin_out == shared_port_pin_dout)
    else $error("pin output differs from data");
  chk_ain_gate: assert property (
    analog_input_0 == (shared_port_pin_oe ? 1'b0 : shared_port_pin_in))
    else $error("analog input not gated by direction");
  chk_ref_sel: assert property (
    s_wr(OFF_REFLIM) |=> pos_reference == $past(pwdata[7:6]))
    else $error("reference select not taken from write");
  chk_end_single: assert property (conv_end_pulse |=> !conv_end_pulse)
    else $error("end pulse longer than one cycle");
  chk_end_active: assert property (conv_end_pulse |-> $past(conv_active))
    else $error("end pulse without active conversion");
  chk_run_stop: assert property (
    s_wr(OFF_MODE0) ##0 !pwdata[B_RUN] |-> ##[1:2] !conv_active)
    else $error("conversion kept running after stop");
  chk_irq_mask: assert property (
    s_wr(OFF_IRQ_EN) ##0 pwdata[1:0] == 2'b00 |=> !irq)
    else $error("interrupt not masked");
  chk_conv_len: assert property ($rose(conv_active) |-> !conv_end_pulse [*2])
    else $error("conversion ended too soon");
endmodule : admtc_top_chk
bind admtc_top admtc_top_chk #(.CONV_TICKS(CONV_TICKS), .FCLK_MHZ(FCLK_MHZ)) chk_inst (.*);

// ---- verification/admtc_trig_model.sv ----
// Purpose: Model of the hardware trigger sources
// Assumes: Each source raises a one-cycle high pulse
// Notes: Only the commanded source pulses, others stay low
`timescale 1ns/100ps
module admtc_trig_model (
  // Clock
  input wire logic pclk,
  // Command from the bench
  input wire logic fire,
  input wire logic [1:0] src,
  // Timer, event link, clock, interval
  output logic [3:0] trig
);
  // Quiet until the first command
  initial trig = 4'h0;
  // One pulse a cycle after each command
  always @(posedge pclk) begin
    trig <= fire ? 4'h1 << src : 4'h0;
  end
endmodule : admtc_trig_model

// ---- verification/admtc_top_tb.sv ----
// Purpose: Self-checking bench for the converter control block
// Assumes: Read data is compared at the access edge
// Notes: Conversion shortened to two divider ticks
`timescale 1ns/100ps
module admtc_top_tb import admtc_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, ext_lvl = 0, pin_dout = 0, pin_out, pin_oe, ain, conv_active;
  logic conv_end, irq, fire = 0, r;
  wire pin_in;
  logic [1:0] pos_ref, src = 2'b00;
  logic [3:0] trig;
  logic [31:0] exp_q[$];
  logic [31:0] bad_v[5] = '{32'h04, 32'h06, 32'h38, 32'h30, 32'h02};
  logic [31:0] bad_s[5] = '{32'h2, 32'h2, 32'h2, 32'h0, 32'h0};
  int err_total = 0, check_count = 0, ends = 0;
  // Wire level: the block drives only while enabled
  assign pin_in = pin_oe ? pin_out : ext_lvl;
  always #25 pclk = ~pclk;
  admtc_top #(.CONV_TICKS(2)) admtc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_ch1_interrupt(trig[0]),
    .event_link_controller(trig[1]), .rtc_interrupt(trig[2]), .interval_timer_interrupt(trig[3]),
    .shared_port_pin_in(pin_in), .shared_port_pin_dout(pin_dout), .shared_port_pin_out(pin_out),
    .shared_port_pin_oe(pin_oe), .analog_input_0(ain), .conv_active(conv_active),
    .conv_end_pulse(conv_end), .pos_reference(pos_ref), .irq(irq));
  admtc_trig_model admtc_trig_model_inst (.pclk(pclk), .fire(fire), .src(src), .trig(trig));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // One transfer; request held until pready is seen
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      complete_run();
    end
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  // Wait for k more ends, or watch lim cycles when k is zero
  task wait_ends(input int k, input int lim);
    int e0;
    e0 = ends;
    for (int n = 0; n < lim && (k == 0 || ends < e0 + k); n++) @(negedge pclk);
    chk("ends", 32'(e0 + k), 32'(ends));
    if (ends < e0 + k) complete_run();
  endtask : wait_ends
  task pulse(input int s);
    @(posedge pclk);
    src <= 2'(s);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
  endtask : pulse
  // Read data compared against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready) chk("prdata", exp_q.pop_front(), prdata);
    if (psel && penable && pready) chk("pslverr", 32'h0, 32'(pslverr));
    if (conv_end) ends++;
  end
  initial begin
    void'($urandom(10));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_MODE0, 32'h0);
    rd(OFF_TRIG, 32'h0);
    rd(OFF_REFLIM, 32'h0);
    rd(OFF_PINDIR, 32'h1);
    for (int i = 0; i < 4; i++) begin
      ext_lvl <= 1'($urandom);
      pin_dout <= 1'($urandom);
      wr(OFF_PINDIR, 32'(i % 2));
      @(negedge pclk);
      chk("pin_oe", 32'(i % 2 == 0), 32'(pin_oe));
      chk("ain", (i % 2) ? 32'(ext_lvl) : 32'h0, 32'(ain));
      chk("pin_out", 32'(pin_dout), 32'(pin_out));
    end
    r = 1'($urandom);
    wr(OFF_MODE0, {25'h0, r, 6'h0});
    rd(OFF_MODE0, {25'h0, r, 6'h0});
    wr(OFF_TRIG, 32'hff);
    rd(OFF_TRIG, 32'he3);
    wr(OFF_REFLIM, 32'hff);
    rd(OFF_REFLIM, 32'hed);
    chk("pos_ref", 32'h3, 32'(pos_ref));
    rd(OFF_STATUS, 32'h2);
    wr(OFF_IRQ_EN, 32'h2);
    @(negedge pclk);
    chk("irq", 32'h1, 32'(irq));
    wr(OFF_REFLIM, 32'h40);
    wr(OFF_IRQ_CLR, 32'h3);
    chk("pos_ref", 32'h1, 32'(pos_ref));
    rd(OFF_STATUS, 32'h0);
    foreach (bad_v[i]) begin
      wr(OFF_MODE0, bad_v[i]);
      rd(OFF_STATUS, bad_s[i]);
      wr(OFF_MODE0, 32'h0);
      wr(OFF_IRQ_CLR, 32'h3);
    end
    wr(OFF_IRQ_EN, 32'h1);
    wr(OFF_TRIG, 32'h20);
    wr(OFF_MODE0, 32'hb1);
    wr(OFF_START, 32'h1);
    wait_ends(1, 200);
    rd(OFF_STATUS, 32'h1);
    wr(OFF_IRQ_EN, 32'h0);
    @(negedge pclk);
    chk("irq", 32'h0, 32'(irq));
    wr(OFF_IRQ_EN, 32'h1);
    wr(OFF_IRQ_CLR, 32'h1);
    @(negedge pclk);
    chk("irq", 32'h0, 32'(irq));
    wait_ends(0, 60);
    wr(OFF_TRIG, 32'h0);
    wr(OFF_START, 32'h1);
    wait_ends(2, 300);
    wr(OFF_MODE0, 32'h31);
    wait_ends(0, 60);
    for (int m = 2; m < 4; m++) begin
      for (int s = 0; s < 4; s++) begin
        wr(OFF_TRIG, 32'(m * 64 + 32 + s));
        wr(OFF_MODE0, 32'hb1);
        rd(OFF_MODE0, 32'hb1);
        pulse(s ^ 1);
        wait_ends(0, 40);
        pulse(s);
        wait_ends(1, 200);
        wr(OFF_MODE0, 32'h31);
      end
    end
    complete_run();
  end
endmodule : admtc_top_tb
